/* File: pkg/cpp_pkg.sv */
// Shared constants for the control port and its external strobe master
package cpp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CPP_IDX_PARALLEL = 8'h08;
  localparam logic [7:0] CPP_IDX_PORT = 8'h09;
  localparam logic [7:0] CPP_IDX_DIR = 8'h89;
  localparam logic [7:0] CPP_IDX_ACFG = 8'h9F;
  localparam logic [11:0] CPP_ADDR_PARALLEL = {2'h0, CPP_IDX_PARALLEL, 2'h0};
  localparam logic [11:0] CPP_ADDR_PORT = {2'h0, CPP_IDX_PORT, 2'h0};
  localparam logic [11:0] CPP_ADDR_DIR = {2'h0, CPP_IDX_DIR, 2'h0};
  localparam logic [11:0] CPP_ADDR_ACFG = {2'h0, CPP_IDX_ACFG, 2'h0};

  // Direction and flags register fields
  localparam int CPP_BIT_IBF = 7;
  localparam int CPP_BIT_OBF = 6;
  localparam int CPP_BIT_INPUT_OVERFLOW_FLAG = 5;
  localparam int CPP_BIT_MODE = 4;
  localparam logic [2:0] CPP_DIR_RESET = 3'h7;
  localparam logic [2:0] CPP_ACFG_RESET = 3'h0;
  localparam logic [7:0] CPP_BYTE_RESET = 8'h00;
  localparam logic [2:0] CPP_PORT_RESET = 3'h0;

  // Pin positions within the three-pin port
  localparam int CPP_PIN_RD = 0;
  localparam int CPP_PIN_WR = 1;
  localparam int CPP_PIN_CS = 2;

  // Digital-pin mask per configuration code, three bits per code, code 0 in the low bits
  localparam logic [23:0] CPP_DIGITAL_MAP_DEFAULT = 24'hFFFFF8;

  // Strobe master registers
  localparam logic [11:0] CPP_HADDR_CMD = 12'h000;
  localparam logic [11:0] CPP_HADDR_STAT = 12'h004;
  localparam int CPP_HCMD_READ_BIT = 8;
  localparam int CPP_HCMD_NOSEL_BIT = 9;
  localparam logic [2:0] CPP_HOST_STROBE_CYC = 3'h4;

endpackage : cpp_pkg

/* File: pkg/cpp_if.sv */
// Pin-level carrier joining the control port and the external strobe master
`timescale 1ns/100ps
interface cpp_if;
  logic [2:0] dev_pin_o;
  logic [2:0] dev_pin_oe;
  logic [2:0] host_pin_o;
  logic [2:0] host_pin_oe;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [2:0] pin_lvl;
  logic [7:0] data_lvl;

  // Wire levels; undriven lines float high
  genvar gi;
  for (gi = 0; gi < 3; gi++)
  begin : g_pin
    assign pin_lvl[gi] = dev_pin_oe[gi] ? dev_pin_o[gi] : (host_pin_oe[gi] ? host_pin_o[gi] : 1'b1);
  end
  assign data_lvl = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hFF);

  modport dev (output dev_pin_o, dev_pin_oe, dev_data_o, dev_data_oe, input pin_lvl, data_lvl);
  modport host (output host_pin_o, host_pin_oe, host_data_o, host_data_oe, input pin_lvl, data_lvl);
endinterface : cpp_if

/* File: rtl/cpp_host.sv */
// External microprocessor end: drives select, read and write strobes
`timescale 1ns/100ps
module cpp_host
  import cpp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  cpp_if.host link
);

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} cpp_hstate_t;

  cpp_hstate_t state_q;
  cpp_hstate_t state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic rd_op_q;
  logic nosel_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [2:0] pins_q;
  logic [2:0] pins_d;
  logic [31:0] prdata_q;

  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i;
  wire hit_cmd = (paddr_i == CPP_HADDR_CMD);
  wire hit_stat = (paddr_i == CPP_HADDR_STAT);
  wire busy = (state_q != H_IDLE);
  wire start = acc & pwrite_i & hit_cmd & ~busy;
  wire strobe_last = (state_q == H_STROBE) & (cnt_q == 3'h1);
  wire [31:0] rdata_mux = hit_stat ? {16'h0000, rdata_q, 7'h00, busy} : 32'h00000000;

  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~(hit_cmd | hit_stat);
  assign prdata_o = prdata_q;
  assign link.host_pin_o = pins_q;
  assign link.host_pin_oe = 3'h7;
  assign link.host_data_o = wdata_q;
  assign link.host_data_oe = busy & ~rd_op_q & (state_q != H_HOLD);

  // Strobe sequence and pin levels
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pins_d = 3'h7;
    unique case (state_q)
      H_IDLE:
      begin
        if (start)
        begin
          state_d = H_SETUP;
        end
      end
      H_SETUP:
      begin
        state_d = H_STROBE;
        cnt_d = CPP_HOST_STROBE_CYC;
        pins_d[CPP_PIN_CS] = nosel_q;
        pins_d[rd_op_q ? CPP_PIN_RD : CPP_PIN_WR] = 1'b0;
      end
      H_STROBE:
      begin
        cnt_d = cnt_q - 3'h1;
        if (strobe_last)
        begin
          state_d = H_HOLD;
        end
        else
        begin
          pins_d[CPP_PIN_CS] = nosel_q;
          pins_d[rd_op_q ? CPP_PIN_RD : CPP_PIN_WR] = 1'b0;
        end
      end
      H_HOLD:
      begin
        state_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= H_IDLE;
      cnt_q <= 3'h0;
      pins_q <= 3'h7;
      rd_op_q <= 1'b0;
      nosel_q <= 1'b0;
      wdata_q <= CPP_BYTE_RESET;
      rdata_q <= CPP_BYTE_RESET;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      if (start)
      begin
        rd_op_q <= pwdata_i[CPP_HCMD_READ_BIT];
        nosel_q <= pwdata_i[CPP_HCMD_NOSEL_BIT];
        wdata_q <= pwdata_i[7:0];
      end
      if (strobe_last & rd_op_q)
      begin
        rdata_q <= link.data_lvl;
      end
      if (setup)
      begin
        prdata_q <= rdata_mux;
      end
    end
  end

endmodule : cpp_host

/* File: rtl/cpp_port.sv */
// Three-pin control port with direction, analog select and parallel-slave flags
// Functional notes
// - Three pins, each with own direction bit
// - Select bit turns pins into strobe inputs
// - Software sets pins input and digital first
// - Configuration field picks analog or digital
// - Analog pins read back as zero
// - Direction drives pins even when analog
// - Power-on reset makes all pins analog
// - Bit 6 output-full flag, read-only
// - Bit 5 overflow on unread write, zero clears
// - Bit 4 selects parallel-slave mode
// - Bit 3 always reads zero
// - Bits 2..0 direct select, write, read pins
// - Flags and mode reset 0, directions 1
// - Read strobe with select presents output latch
// - Write strobe with select captures input byte
// - Select high ignores both strobes
// - Data register reads the three pin levels
// - Reads see pins, writes load latch
// - Read-modify-write stores whole result into latch
// - Input-full clears on core read, off-mode clear
// - Output-full clears on external read start
`timescale 1ns/100ps
module cpp_port
  import cpp_pkg::*;
#(
  parameter logic [23:0] DIGITAL_MAP = CPP_DIGITAL_MAP_DEFAULT
)
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic psp_mode_o,
  output logic [2:0] analog_sel_o,
  cpp_if.dev link
);

  logic [2:0] port_lat_q;
  logic [2:0] dir_q;
  logic [2:0] dir_d;
  logic mode_q;
  logic mode_d;
  logic ibf_q;
  logic ibf_d;
  logic obf_q;
  logic obf_d;
  logic input_overflow_flag_q;
  logic input_overflow_flag_d;
  logic [2:0] acfg_q;
  logic [7:0] in_lat_q;
  logic [7:0] out_lat_q;
  logic wr_act_q;
  logic rd_act_q;
  logic [31:0] prdata_q;

  // Bus decode
  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i;
  wire hit_par = (paddr_i == CPP_ADDR_PARALLEL);
  wire hit_port = (paddr_i == CPP_ADDR_PORT);
  wire hit_dir = (paddr_i == CPP_ADDR_DIR);
  wire hit_acfg = (paddr_i == CPP_ADDR_ACFG);
  wire hit_any = hit_par | hit_port | hit_dir | hit_acfg;
  wire wr_par = acc & pwrite_i & hit_par;
  wire wr_port = acc & pwrite_i & hit_port;
  wire wr_dir = acc & pwrite_i & hit_dir;
  wire wr_acfg = acc & pwrite_i & hit_acfg;
  wire rd_par = acc & ~pwrite_i & hit_par;

  // Analog versus digital per pin
  wire [4:0] map_base = {acfg_q, 1'b0} + {2'b00, acfg_q};
  wire [2:0] dig_mask = DIGITAL_MAP[map_base +: 3];
  logic [2:0] port_rd;

  // Per-pin driver and readback
  genvar pi;
  for (pi = 0; pi < 3; pi++)
  begin : g_pin
    assign port_rd[pi] = link.pin_lvl[pi] & dig_mask[pi];
    assign link.dev_pin_o[pi] = port_lat_q[pi];
    assign link.dev_pin_oe[pi] = ~dir_q[pi];
  end

  // Parallel-slave strobes, active low, gated by select
  wire cs_act = mode_q & ~link.pin_lvl[CPP_PIN_CS];
  wire wr_act = cs_act & ~link.pin_lvl[CPP_PIN_WR];
  wire rd_act = cs_act & ~link.pin_lvl[CPP_PIN_RD];
  wire wr_start = wr_act & ~wr_act_q;
  wire wr_end = ~wr_act & wr_act_q;
  wire rd_start = rd_act & ~rd_act_q;

  wire [7:0] dir_rd = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, dir_q};
  wire [31:0] rdata_mux = hit_par ? {24'h000000, in_lat_q} :
                          hit_port ? {29'h00000000, port_rd} :
                          hit_dir ? {24'h000000, dir_rd} :
                          hit_acfg ? {29'h00000000, acfg_q} : 32'h00000000;

  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit_any;
  assign prdata_o = prdata_q;
  assign psp_mode_o = mode_q;
  assign analog_sel_o = ~dig_mask;
  assign link.dev_data_o = out_lat_q;
  assign link.dev_data_oe = rd_act;

  // Flag and control next values; hardware set wins over clear
  always_comb
  begin
    ibf_d = mode_q & (wr_end | (ibf_q & ~rd_par));
    obf_d = mode_q & (wr_par | (obf_q & ~rd_start));
    input_overflow_flag_d = (wr_start & ibf_q) | (input_overflow_flag_q & ~(wr_dir & ~pwdata_i[CPP_BIT_INPUT_OVERFLOW_FLAG]));
    mode_d = wr_dir ? pwdata_i[CPP_BIT_MODE] : mode_q;
    dir_d = wr_dir ? pwdata_i[2:0] : dir_q;
  end

  // Parallel-slave flags
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ibf_q <= 1'b0;
      obf_q <= 1'b0;
      input_overflow_flag_q <= 1'b0;
    end
    else
    begin
      ibf_q <= ibf_d;
      obf_q <= obf_d;
      input_overflow_flag_q <= input_overflow_flag_d;
    end
  end

  // Mode and pin directions
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_q <= 1'b0;
      dir_q <= CPP_DIR_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      dir_q <= dir_d;
    end
  end

  // Analog configuration
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acfg_q <= CPP_ACFG_RESET;
    end
    else if (wr_acfg)
    begin
      acfg_q <= pwdata_i[2:0];
    end
  end

  // Strobe history for edge detection
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // Port output latch
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_lat_q <= CPP_PORT_RESET;
    end
    else if (wr_port)
    begin
      port_lat_q <= pwdata_i[2:0];
    end
  end

  // Parallel input latch
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      in_lat_q <= CPP_BYTE_RESET;
    end
    else if (wr_act)
    begin
      in_lat_q <= link.data_lvl;
    end
  end

  // Parallel output latch
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      out_lat_q <= CPP_BYTE_RESET;
    end
    else if (wr_par)
    begin
      out_lat_q <= pwdata_i[7:0];
    end
  end

  // Read data taken in the setup cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setup)
    begin
      prdata_q <= rdata_mux;
    end
  end

endmodule : cpp_port

/* File: test/cpp_monitor.sv */
// Pin-level checks across the port and strobe master link
`timescale 1ns/100ps
module cpp_monitor
(
  input logic core_clk_i,
  input logic arst_n_i,
  input logic [2:0] host_pin_o,
  input logic [2:0] host_pin_oe,
  input logic host_data_oe,
  input logic [7:0] dev_data_o,
  input logic dev_data_oe,
  input logic [2:0] pin_lvl,
  input logic [7:0] data_lvl
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_sel_read;
    dev_data_oe |-> !pin_lvl[0] && !pin_lvl[2];
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("data driven without select and read");
  property p_rd_data;
    dev_data_oe |-> data_lvl == dev_data_o;
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("bus does not carry output latch");
  property p_desel;
    $rose(pin_lvl[2]) |-> !dev_data_oe;
  endproperty
  a_desel: assert property (p_desel)
    else $error("data driven while deselected");
  property p_contend;
    !(dev_data_oe && host_data_oe);
  endproperty
  a_contend: assert property (p_contend)
    else $error("both ends drive the data bus");
  property p_host_oe;
    host_pin_oe == 3'h7;
  endproperty
  a_host_oe: assert property (p_host_oe)
    else $error("strobe pins released by master");
  property p_strobe;
    $fell(host_pin_o[2]) |-> !host_pin_o[2] [*4] ##1 host_pin_o == 3'h7;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe width wrong");
  property p_wr_data;
    !host_pin_o[1] |-> host_data_oe;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write strobe without data");
  property p_one_strobe;
    !host_pin_o[1] |-> host_pin_o[0];
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobes together");
  property p_desel_quiet;
    pin_lvl[2] |-> !dev_data_oe;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet)
    else $error("data driven while select is high");
endmodule : cpp_monitor

/* File: test/cpp_tb_top.sv */
// Testbench joining port and strobe master over the link
`timescale 1ns/100ps
module cpp_tb_top;
  import cpp_pkg::*;
  logic core_clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [1:0] psel = 2'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata [2];
  logic [1:0] rdy;
  logic [1:0] err;
  logic psp_mode;
  logic [2:0] an_sel;
  int n_fail = 0;
  int checks = 0;
  cpp_if link ();
  cpp_port i_cpp_port (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel[0]),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata[0]), .pready_o(rdy[0]), .pslverr_o(err[0]), .psp_mode_o(psp_mode),
    .analog_sel_o(an_sel), .link(link));
  cpp_host i_cpp_host (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel[1]),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata[1]), .pready_o(rdy[1]), .pslverr_o(err[1]), .link(link));
  cpp_monitor i_cpp_monitor (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .host_pin_o(link.host_pin_o), .host_pin_oe(link.host_pin_oe), .host_data_oe(link.host_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe), .pin_lvl(link.pin_lvl),
    .data_lvl(link.data_lvl));

  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  function automatic string item_name(input logic [11:0] id);
    string s;
    s = "item";
    case (id)
      CPP_ADDR_DIR: s = "direction_flags";
      CPP_ADDR_ACFG: s = "analog_config";
      CPP_ADDR_PORT: s = "port_data";
      CPP_ADDR_PARALLEL: s = "parallel_latch";
      CPP_HADDR_STAT: s = "master_status";
      12'h008: s = "master_unmapped";
      12'h3F0: s = "port_unmapped";
      12'hA00: s = "analog_select";
      12'hA01: s = "pin_enable";
      12'hA02: s = "mode_output";
      default: s = "item";
    endcase
    return s;
  endfunction : item_name

  task automatic chk(input logic [11:0] id, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", item_name(id), exp, got);
    end
  endtask : chk

  task automatic apb(input logic h, input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel[h] <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'h1;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (rdy[h] !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      complete_run;
    end
    r = prdata[h];
    e = err[h];
    psel[h] <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk_i);
  endtask : apb

  task automatic wr(input logic h, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(h, 1'h1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic h, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(h, 1'h0, a, 32'h0, r, e);
    chk(a, r & m, x);
  endtask : rd

  task automatic hx(input logic [31:0] cmd);
    logic [31:0] r;
    logic e;
    int n;
    wr(1'h1, CPP_HADDR_CMD, cmd);
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'h0 && n < 40)
    begin
      apb(1'h1, 1'h0, CPP_HADDR_STAT, 32'h0, r, e);
      n++;
    end
    if (r[0] !== 1'h0)
    begin
      n_fail++;
      complete_run;
    end
  endtask : hx

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    complete_run;
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'h1;
    @(posedge core_clk_i);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h07);
    rd(1'h0, CPP_ADDR_ACFG, 32'hFFFFFFFF, 32'h00);
    chk(12'hA00, {29'h0, an_sel}, 32'h7);
    rd(1'h0, CPP_ADDR_PORT, 32'hFFFFFFFF, 32'h0);
    wr(1'h0, CPP_ADDR_DIR, 32'h06);
    wr(1'h0, CPP_ADDR_ACFG, 32'h01);
    rd(1'h0, CPP_ADDR_PORT, 32'hFFFFFFFF, 32'h6);
    apb(1'h0, 1'h0, CPP_ADDR_PORT, 32'h0, r, e);
    wr(1'h0, CPP_ADDR_PORT, r | 32'h1);
    wr(1'h0, CPP_ADDR_DIR, 32'h00);
    rd(1'h0, CPP_ADDR_PORT, 32'hFFFFFFFF, 32'h7);
    wr(1'h0, CPP_ADDR_ACFG, 32'h00);
    rd(1'h0, CPP_ADDR_PORT, 32'hFFFFFFFF, 32'h0);
    chk(12'hA01, {29'h0, link.dev_pin_oe}, 32'h7);
    apb(1'h0, 1'h0, 12'h3F0, 32'h0, r, e);
    chk(12'h3F0, {31'h0, e}, 32'h1);
    apb(1'h1, 1'h0, 12'h008, 32'h0, r, e);
    chk(12'h008, {31'h0, e}, 32'h1);
    wr(1'h0, CPP_ADDR_ACFG, 32'h01);
    wr(1'h0, CPP_ADDR_DIR, 32'h17);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h17);
    chk(12'hA02, {31'h0, psp_mode}, 32'h1);
    hx(32'hA5);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h97);
    hx(32'h3C);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'hB7);
    rd(1'h0, CPP_ADDR_PARALLEL, 32'hFFFFFFFF, 32'h3C);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h37);
    wr(1'h0, CPP_ADDR_DIR, 32'hFF);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h37);
    wr(1'h0, CPP_ADDR_DIR, 32'h17);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h17);
    wr(1'h0, CPP_ADDR_PARALLEL, 32'h5A);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h57);
    hx(32'h100);
    rd(1'h1, CPP_HADDR_STAT, 32'hFF00, 32'h5A00);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h17);
    hx(32'h2EE);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h17);
    rd(1'h0, CPP_ADDR_PARALLEL, 32'hFFFFFFFF, 32'h3C);
    wr(1'h0, CPP_ADDR_PARALLEL, 32'h11);
    hx(32'h300);
    rd(1'h1, CPP_HADDR_STAT, 32'hFF00, 32'hFF00);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h57);
    wr(1'h0, CPP_ADDR_DIR, 32'h07);
    rd(1'h0, CPP_ADDR_DIR, 32'hFFFFFFFF, 32'h07);
    hx(32'h22);
    rd(1'h0, CPP_ADDR_PARALLEL, 32'hFFFFFFFF, 32'h3C);
    complete_run;
  end
endmodule : cpp_tb_top
